// ### core/tpwm_prescaler.sv
// count clock prescaler: one-cycle tick enables from the peripheral clock or low-speed osc
// assumes losc_tick_i is a one-cycle pulse per low-speed oscillator period, synchronous to core_clk_i
`timescale 1ns/100ps
module tpwm_prescaler
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [2:0] clk_sel_i,
  input wire logic losc_tick_i,
  // tick out
  output logic tick_o
);
  logic [tpwm_pkg::DIV_WIDTH-1:0] div_r;
  logic [tpwm_pkg::DIV_WIDTH-1:0] div_nxt;
  logic [tpwm_pkg::LOSC_DIV_WIDTH-1:0] ldiv_r;
  logic [tpwm_pkg::LOSC_DIV_WIDTH-1:0] ldiv_nxt;
  logic tick_nxt;
  logic tick_r;

  // ==========================================================
  // dividers, held at zero while stopped so every start is aligned
  always_comb
  begin
    div_nxt = run_i ? div_r + 1'b1 : '0;
    ldiv_nxt = ldiv_r;
    if (!run_i)
    begin
      ldiv_nxt = '0;
    end
    else if (losc_tick_i)
    begin
      ldiv_nxt = ldiv_r + 1'b1;
    end
    // RL15 count clock select
    case (clk_sel_i)
      tpwm_pkg::CKS_DIV1: tick_nxt = run_i;
      tpwm_pkg::CKS_DIV4: tick_nxt = run_i && (div_r[1:0] == 2'h3);
      tpwm_pkg::CKS_DIV16: tick_nxt = run_i && (div_r[3:0] == 4'hf);
      tpwm_pkg::CKS_DIV64: tick_nxt = run_i && (div_r[5:0] == 6'h3f);
      tpwm_pkg::CKS_DIV4096: tick_nxt = run_i && (div_r == 12'hfff);
      tpwm_pkg::CKS_LOSC: tick_nxt = run_i && losc_tick_i && (ldiv_r == 7'h7f);
      // prohibited codes never tick
      default: tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      div_r <= '0;
      ldiv_r <= '0;
      tick_r <= 1'b0;
    end
    else
    begin
      div_r <= div_nxt;
      ldiv_r <= ldiv_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r && run_i;
endmodule

// ### core/tpwm_timer.sv
// 8-bit timer with pwm output mode and interval mode, apb register slave
// assumes an apb master on core_clk_i; pin is push-pull, enable high while driving
// Notes on behaviour
// RL1 - software leaves the period compare alone while counting runs
// RL2 - after start the period compare is checked before the duty compare
// RL3 - period match clears counter, pulses irq, drives output active, selects duty
// RL4 - duty match drives output inactive, selects period, no clear, no irq
// RL5 - first count clock after start is masked; output idles until first period match
// RL6 - period is (N+1) count clocks, active width is (M+1) clocks
// RL7 - software keeps duty below period, both within 00h to ffh
// RL8 - duty writes go to a buffer, loaded at the old duty match
// RL9 - buffer transfer needs three count clocks after the write
// RL10 - duty writes are accepted at any time during counting
// RL11 - clearing run makes irq and output inactive at once
// RL12 - software rewrites duty on every restart
// RL13 - clearing run stops and zeroes the counter; setting run starts it
// RL14 - software changes no other mode bit while run is set
// RL15 - clock select picks div 1, 4, 16, 64, 4096 or low-speed osc div 128
// RL16 - mode 10 selects pwm, 00 interval; output reaches pin only when gated on
`timescale 1ns/100ps
module tpwm_timer
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // low-speed oscillator tick
  input wire logic losc_tick_i,
  // pin and interrupts
  output logic pwm_out_pin_o,
  output logic pwm_out_pin_oe_o,
  output logic period_match_irq_o,
  output logic irq_o
);
  typedef enum logic [1:0] {CMP_IDLE, CMP_PERIOD, CMP_DUTY} tpwm_cmp_type;

  logic [7:0] timer_mode_reg_r;
  logic [7:0] timer_mode_reg_nxt;
  logic [7:0] period_compare_r;
  logic [7:0] period_compare_nxt;
  logic [7:0] duty_compare_r;
  logic [7:0] duty_compare_nxt;
  logic [7:0] duty_buf_r;
  logic [7:0] duty_buf_nxt;
  logic duty_pend_r;
  logic duty_pend_nxt;
  logic [1:0] xfer_cnt_r;
  logic [1:0] xfer_cnt_nxt;
  logic [7:0] count_r;
  logic [7:0] count_nxt;
  tpwm_cmp_type cmp_r;
  tpwm_cmp_type cmp_nxt;
  logic masked_r;
  logic masked_nxt;
  logic out_r;
  logic out_nxt;
  logic irq_pulse_r;
  logic irq_pulse_nxt;
  logic [tpwm_pkg::ST_WIDTH-1:0] status_r;
  logic [tpwm_pkg::ST_WIDTH-1:0] status_nxt;
  logic [tpwm_pkg::ST_WIDTH-1:0] mask_r;
  logic [tpwm_pkg::ST_WIDTH-1:0] mask_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pslverr_r;
  logic pslverr_nxt;

  logic run;
  logic pwm_mode;
  logic tick;
  logic wr;
  logic rd;
  logic setup;
  logic addr_ok;
  logic period_hit;
  logic duty_hit;
  logic [tpwm_pkg::ST_WIDTH-1:0] events;

  assign run = timer_mode_reg_r[tpwm_pkg::RUN_POS];
  assign pwm_mode = timer_mode_reg_r[tpwm_pkg::MODE_HI:tpwm_pkg::MODE_LO] == tpwm_pkg::MODE_PWM;
  // zero-wait slave: setup cycle computes answer, access cycle completes
  assign setup = psel_i && !penable_i;
  assign wr = psel_i && penable_i && pwrite_i;
  assign rd = psel_i && penable_i && !pwrite_i;
  assign addr_ok = paddr_i == tpwm_pkg::MODE_ADDR || paddr_i == tpwm_pkg::PERIOD_ADDR
    || paddr_i == tpwm_pkg::DUTY_ADDR || paddr_i == tpwm_pkg::STATUS_ADDR
    || paddr_i == tpwm_pkg::MASK_ADDR || paddr_i == tpwm_pkg::COUNT_ADDR;

  // ==========================================================
  // count clock
  tpwm_prescaler u_prescaler
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .run_i(run),
    .clk_sel_i(timer_mode_reg_r[tpwm_pkg::CKS_HI:tpwm_pkg::CKS_LO]),
    .losc_tick_i(losc_tick_i),
    .tick_o(tick)
  );

  // ==========================================================
  // compare logic
  assign period_hit = tick && !masked_r && cmp_r != CMP_DUTY && count_r == period_compare_r;
  assign duty_hit = tick && !masked_r && pwm_mode && cmp_r == CMP_DUTY && count_r == duty_compare_r;

  always_comb
  begin
    count_nxt = count_r;
    cmp_nxt = cmp_r;
    masked_nxt = masked_r;
    out_nxt = out_r;
    irq_pulse_nxt = 1'b0;
    duty_compare_nxt = duty_compare_r;
    if (!run)
    begin
      // RL13 stop clears count
      count_nxt = '0;
      cmp_nxt = CMP_IDLE;
      masked_nxt = 1'b1;
      // RL11 stop forces inactive
      out_nxt = 1'b0;
    end
    else if (tick)
    begin
      if (masked_r)
      begin
        // RL5 first count clock swallowed
        masked_nxt = 1'b0;
        // RL2 period compared first
        cmp_nxt = CMP_PERIOD;
      end
      else if (period_hit)
      begin
        // RL3 period match actions
        count_nxt = '0;
        irq_pulse_nxt = 1'b1;
        // RL6 active for M+1 clocks from here
        out_nxt = pwm_mode ? 1'b1 : !out_r;
        cmp_nxt = pwm_mode ? CMP_DUTY : CMP_PERIOD;
      end
      else if (duty_hit)
      begin
        // RL4 duty match actions
        count_nxt = count_r + 1'b1;
        out_nxt = 1'b0;
        cmp_nxt = CMP_PERIOD;
      end
      else
      begin
        count_nxt = count_r + 1'b1;
      end
    end
    // RL8 load buffer at old duty match
    // RL9 only after three count clocks
    if (duty_hit && duty_pend_r && xfer_cnt_r == tpwm_pkg::DUTY_XFER_TICKS)
    begin
      duty_compare_nxt = duty_buf_r;
    end
    else if (!run && wr && paddr_i == tpwm_pkg::DUTY_ADDR)
    begin
      duty_compare_nxt = pwdata_i[7:0];
    end
  end

  // ==========================================================
  // duty buffer
  always_comb
  begin
    duty_buf_nxt = duty_buf_r;
    duty_pend_nxt = duty_pend_r;
    xfer_cnt_nxt = xfer_cnt_r;
    if (duty_hit && duty_pend_r && xfer_cnt_r == tpwm_pkg::DUTY_XFER_TICKS)
    begin
      duty_pend_nxt = 1'b0;
    end
    else if (tick && duty_pend_r && xfer_cnt_r != tpwm_pkg::DUTY_XFER_TICKS)
    begin
      xfer_cnt_nxt = xfer_cnt_r + 1'b1;
    end
    if (!run)
    begin
      duty_pend_nxt = 1'b0;
      xfer_cnt_nxt = '0;
    end
    // RL10 write accepted any time
    if (wr && paddr_i == tpwm_pkg::DUTY_ADDR)
    begin
      duty_buf_nxt = pwdata_i[7:0];
      duty_pend_nxt = run;
      xfer_cnt_nxt = '0;
    end
  end

  // ==========================================================
  // registers, status and bus answer
  assign events[tpwm_pkg::ST_PERIOD] = period_hit;
  assign events[tpwm_pkg::ST_DUTY] = duty_hit;

  always_comb
  begin
    timer_mode_reg_nxt = timer_mode_reg_r;
    period_compare_nxt = period_compare_r;
    mask_nxt = mask_r;
    status_nxt = status_r;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (wr && paddr_i == tpwm_pkg::MODE_ADDR)
    begin
      timer_mode_reg_nxt = pwdata_i[7:0];
    end
    // period writes while running are dropped, not merged
    if (wr && paddr_i == tpwm_pkg::PERIOD_ADDR && !run)
    begin
      period_compare_nxt = pwdata_i[7:0];
    end
    if (wr && paddr_i == tpwm_pkg::MASK_ADDR)
    begin
      mask_nxt = pwdata_i[tpwm_pkg::ST_WIDTH-1:0];
    end
    // read clears, but a same-cycle event survives
    if (rd && paddr_i == tpwm_pkg::STATUS_ADDR)
    begin
      status_nxt = '0;
    end
    status_nxt = status_nxt | events;
    if (setup)
    begin
      pslverr_nxt = !addr_ok;
      case (paddr_i)
        tpwm_pkg::MODE_ADDR: prdata_nxt = {24'h000000, timer_mode_reg_r};
        tpwm_pkg::PERIOD_ADDR: prdata_nxt = {24'h000000, period_compare_r};
        tpwm_pkg::DUTY_ADDR: prdata_nxt = {24'h000000, duty_compare_r};
        tpwm_pkg::STATUS_ADDR: prdata_nxt = {30'h0, status_r | events};
        tpwm_pkg::MASK_ADDR: prdata_nxt = {30'h0, mask_r};
        tpwm_pkg::COUNT_ADDR: prdata_nxt = {24'h000000, count_r};
        default: prdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      timer_mode_reg_r <= tpwm_pkg::MODE_RST;
      period_compare_r <= tpwm_pkg::PERIOD_RST;
      duty_compare_r <= tpwm_pkg::DUTY_RST;
      duty_buf_r <= tpwm_pkg::DUTY_RST;
      duty_pend_r <= 1'b0;
      xfer_cnt_r <= '0;
      count_r <= '0;
      cmp_r <= CMP_IDLE;
      masked_r <= 1'b1;
      out_r <= 1'b0;
      irq_pulse_r <= 1'b0;
      status_r <= '0;
      mask_r <= '0;
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
    end
    else
    begin
      timer_mode_reg_r <= timer_mode_reg_nxt;
      period_compare_r <= period_compare_nxt;
      duty_compare_r <= duty_compare_nxt;
      duty_buf_r <= duty_buf_nxt;
      duty_pend_r <= duty_pend_nxt;
      xfer_cnt_r <= xfer_cnt_nxt;
      count_r <= count_nxt;
      cmp_r <= cmp_nxt;
      masked_r <= masked_nxt;
      out_r <= out_nxt;
      irq_pulse_r <= irq_pulse_nxt;
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // ==========================================================
  // outputs
  assign prdata_o = prdata_r;
  assign pready_o = 1'b1;
  assign pslverr_o = pslverr_r && psel_i && penable_i;
  // RL16 gate and idle level
  // RL11 run gates pin: out_r only clears a cycle after the stop write
  assign pwm_out_pin_o = timer_mode_reg_r[tpwm_pkg::GATE_POS]
    && ((out_r && run) ^ timer_mode_reg_r[tpwm_pkg::LEVEL_POS]);
  assign pwm_out_pin_oe_o = timer_mode_reg_r[tpwm_pkg::GATE_POS];
  // RL11 irq pulse killed by stop
  assign period_match_irq_o = irq_pulse_r && run;
  assign irq_o = |(status_r & mask_r);
endmodule

// ### shared/tpwm_pkg.sv
// constants for the timer pwm block: apb register map, field layout, prescaler taps
// assumes a 32-bit apb master and byte addresses that are word aligned
package tpwm_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] MODE_ADDR = 8'h00;
  localparam logic [7:0] PERIOD_ADDR = 8'h04;
  localparam logic [7:0] DUTY_ADDR = 8'h08;
  localparam logic [7:0] STATUS_ADDR = 8'h0c;
  localparam logic [7:0] MASK_ADDR = 8'h10;
  localparam logic [7:0] COUNT_ADDR = 8'h14;
  // ==========================================================
  // mode register fields
  localparam int RUN_POS = 7;
  localparam int CKS_HI = 6;
  localparam int CKS_LO = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int LEVEL_POS = 1;
  localparam int GATE_POS = 0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'h00;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_INTERVAL = 2'h0;
  // ==========================================================
  // status bits
  localparam int ST_PERIOD = 0;
  localparam int ST_DUTY = 1;
  localparam int ST_WIDTH = 2;
  // ==========================================================
  // clock select codes and divider exponents
  localparam logic [2:0] CKS_DIV1 = 3'h0;
  localparam logic [2:0] CKS_DIV4 = 3'h1;
  localparam logic [2:0] CKS_DIV16 = 3'h2;
  localparam logic [2:0] CKS_DIV64 = 3'h3;
  localparam logic [2:0] CKS_DIV4096 = 3'h4;
  localparam logic [2:0] CKS_LOSC = 3'h5;
  localparam int DIV_WIDTH = 12;
  localparam int LOSC_DIV_WIDTH = 7;
  // a buffered duty write needs this many count clocks to transfer
  localparam logic [1:0] DUTY_XFER_TICKS = 2'h3;
endpackage

// ### verif/test_timer_pwm_output_mode.sv
// bench for the timer pwm block: apb master, pin load, self checks
// assumes a 25 mhz core clock and the load model on the pin
`timescale 1ns/100ps
module test_timer_pwm_output_mode;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic losc_tick_i = 1'b0;
  logic [2:0] lc = 3'h0;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic pwm_out_pin_o;
  logic pwm_out_pin_oe_o;
  logic period_match_irq_o;
  logic irq_o;
  logic [31:0] rq;
  int hi_w;
  int per_w;
  int n_rise;
  int n_fail = 0;
  int compares = 0;
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    lc <= lc + 3'h1;
    losc_tick_i <= (lc == 3'h7);
  end
  tpwm_timer i_tpwm_timer
  (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .losc_tick_i(losc_tick_i),
    .pwm_out_pin_o(pwm_out_pin_o),
    .pwm_out_pin_oe_o(pwm_out_pin_oe_o),
    .period_match_irq_o(period_match_irq_o),
    .irq_o(irq_o)
  );
  tpwm_load i_tpwm_load
  (
    .core_clk_i(core_clk_i),
    .pin_i(pwm_out_pin_o),
    .oe_i(pwm_out_pin_oe_o),
    .hi_w_o(hi_w),
    .per_w_o(per_w),
    .n_rise_o(n_rise)
  );
  // ==========
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do
      @(posedge core_clk_i);
    while (pready_o !== 1'b1);
    rq = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wait_rise(input int k);
    int s;
    s = n_rise;
    while (n_rise < s + k)
      @(posedge core_clk_i);
  endtask
  task automatic t_start(input logic [2:0] sel, input logic lv, input int k);
    // software order: period while stopped, duty below it, rewritten each start
    apb(1'b1, tpwm_pkg::PERIOD_ADDR, 32'h5);
    apb(1'b1, tpwm_pkg::DUTY_ADDR, 32'h2);
    apb(1'b1, tpwm_pkg::MODE_ADDR, {24'h0, 1'b1, sel, 2'h2, lv, 1'b1});
    wait_rise(3);
    chk(per_w, 6 * k);
    chk(hi_w, 3 * k);
  endtask
  task automatic t_stop(input logic [2:0] sel, input logic lv);
    // only run changes while running
    apb(1'b1, tpwm_pkg::MODE_ADDR, {24'h0, 1'b0, sel, 2'h2, lv, 1'b1});
    chk(pwm_out_pin_o, lv);
    apb(1'b0, tpwm_pkg::COUNT_ADDR, 32'h0);
    chk(rq, 32'h0);
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    apb(1'b0, tpwm_pkg::MODE_ADDR, 32'h0);
    chk(rq, 32'h0);
    apb(1'b0, tpwm_pkg::DUTY_ADDR, 32'h0);
    chk(rq, 32'h0);
    apb(1'b1, 8'h40, 32'hff);
  endtask
  task automatic t_basic;
    apb(1'b1, tpwm_pkg::MASK_ADDR, 32'h1);
    t_start(3'h0, 1'b0, 1);
    chk(irq_o, 1'b1);
    apb(1'b0, tpwm_pkg::STATUS_ADDR, 32'h0);
    chk(rq[0], 1'b1);
    apb(1'b1, tpwm_pkg::PERIOD_ADDR, 32'h9);
    apb(1'b0, tpwm_pkg::PERIOD_ADDR, 32'h0);
    chk(rq, 32'h5);
    apb(1'b1, tpwm_pkg::DUTY_ADDR, 32'h0);
    wait_rise(4);
    chk(hi_w, 1);
    t_stop(3'h0, 1'b0);
    apb(1'b0, tpwm_pkg::STATUS_ADDR, 32'h0);
    apb(1'b0, tpwm_pkg::STATUS_ADDR, 32'h0);
    chk(rq, 32'h0);
    chk(irq_o, 1'b0);
  endtask
  task automatic t_prescale;
    apb(1'b1, tpwm_pkg::MASK_ADDR, 32'h0);
    for (int s = 1; s < 3; s++)
    begin
      t_start(3'(s), s[0], 4 ** s);
      chk(irq_o, 1'b0);
      t_stop(3'(s), s[0]);
    end
    apb(1'b1, tpwm_pkg::MODE_ADDR, 32'h0a);
    chk(pwm_out_pin_oe_o, 1'b0);
  endtask
  task automatic t_interval;
    // interval mode: output toggles at each period match
    apb(1'b1, tpwm_pkg::PERIOD_ADDR, 32'h3);
    apb(1'b1, tpwm_pkg::MODE_ADDR, 32'h81);
    wait_rise(3);
    chk(per_w, 8);
    chk(hi_w, 4);
    apb(1'b1, tpwm_pkg::MODE_ADDR, 32'h01);
    chk(pwm_out_pin_o, 1'b0);
    // low-speed osc ticks every 8 clocks here, so one count clock per 1024
    apb(1'b1, tpwm_pkg::PERIOD_ADDR, 32'h1);
    apb(1'b1, tpwm_pkg::DUTY_ADDR, 32'h0);
    apb(1'b1, tpwm_pkg::MODE_ADDR, 32'hd9);
    wait_rise(3);
    chk(per_w, 2048);
    chk(hi_w, 1024);
    apb(1'b1, tpwm_pkg::MODE_ADDR, 32'h59);
    chk(pwm_out_pin_o, 1'b0);
  endtask
  task report_and_stop;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset;
    t_basic;
    t_prescale;
    t_interval;
    report_and_stop;
  end
  // runs take about eight thousand cycles, mostly the low-speed osc case
  initial
  begin
    repeat (30000) @(posedge core_clk_i);
    n_fail++;
    report_and_stop;
  end
endmodule

// ### verif/tpwm_load.sv
// load on the pwm pin: high width and period in core clocks
// assumes a pull-down on the pin while the driver is off
`timescale 1ns/100ps
module tpwm_load
(
  // clock
  input wire logic core_clk_i,
  // pin
  input wire logic pin_i,
  input wire logic oe_i,
  // measurements
  output int hi_w_o,
  output int per_w_o,
  output int n_rise_o
);
  logic lvl;
  logic lvl_d = 1'b0;
  int t_hi = 0;
  int t_per = 0;
  // pulled low when undriven
  assign lvl = oe_i & pin_i;
  // int outputs start at zero, so one process drives each
  always @(posedge core_clk_i)
  begin
    lvl_d <= lvl;
    t_per <= (lvl & !lvl_d) ? 1 : t_per + 1;
    t_hi <= (lvl & !lvl_d) ? 1 : t_hi + int'(lvl);
    if (lvl & !lvl_d)
    begin
      per_w_o <= t_per;
      n_rise_o <= n_rise_o + 1;
    end
    if (!lvl & lvl_d)
      hi_w_o <= t_hi;
  end
endmodule

// ### verif/tpwm_timer_sva.sv
// checker for the timer pwm block, sees only the top ports
// assumes apb writes land at the access edge, pready always high
`timescale 1ns/100ps
module tpwm_timer_chk
(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pin and irq
  input wire logic pwm_out_pin_o,
  input wire logic pwm_out_pin_oe_o,
  input wire logic period_match_irq_o
);
  // ==========
  // mode shadow
  logic [7:0] mode_r;
  logic [7:0] mode_nxt;
  logic acc;
  logic idle;
  assign acc = psel_i & penable_i;
  assign idle = mode_r[0] & mode_r[1];
  always_comb
  begin
    mode_nxt = mode_r;
    if (acc & pwrite_i & (paddr_i == tpwm_pkg::MODE_ADDR))
      mode_nxt = pwdata_i[7:0];
  end
  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      mode_r <= tpwm_pkg::MODE_RST;
    else
      mode_r <= mode_nxt;
  end
  // ==========
  // properties
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  a_ready_high: assert property (acc |-> pready_o) else $error("pready low in access");
  a_slverr_map: assert property (acc && paddr_i > 8'h14 |-> pslverr_o) else $error("no error on hole");
  a_read_upper: assert property (acc && !pwrite_i |-> prdata_o[31:8] == 24'h0) else $error("upper bits set");
  a_gate_pin: assert property (!pwm_out_pin_oe_o |-> !pwm_out_pin_o) else $error("pin high when gated");
  a_gate_oe: assert property (pwm_out_pin_oe_o == mode_r[0]) else $error("enable off gate bit");
  a_stop_idle: assert property (!mode_r[7] && $past(!mode_r[7]) |-> pwm_out_pin_o == idle)
    else $error("stopped pin not idle");
  a_stop_pin_now: assert property (!mode_r[7] |-> pwm_out_pin_o == idle)
    else $error("pin not idle right after stop");
  a_stop_irq: assert property ($fell(mode_r[7]) |=> !period_match_irq_o [*4])
    else $error("irq after stop");
  a_start_masked: assert property ($rose(mode_r[7]) |-> (pwm_out_pin_o == idle) [*2])
    else $error("pin active at start");
  a_match_active: assert property ($rose(period_match_irq_o) && mode_r[3:2] == 2'h2 |->
    pwm_out_pin_o == (mode_r[0] & ~mode_r[1])) else $error("pin not active at match");
  c_match: cover property ($rose(period_match_irq_o));
  c_stop: cover property ($fell(mode_r[7]));
  c_hole: cover property (acc && pslverr_o);
endmodule

bind tpwm_timer tpwm_timer_chk i_tpwm_timer_chk
(
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .psel_i(psel_i),
  .penable_i(penable_i),
  .pwrite_i(pwrite_i),
  .paddr_i(paddr_i),
  .pwdata_i(pwdata_i),
  .prdata_o(prdata_o),
  .pready_o(pready_o),
  .pslverr_o(pslverr_o),
  .pwm_out_pin_o(pwm_out_pin_o),
  .pwm_out_pin_oe_o(pwm_out_pin_oe_o),
  .period_match_irq_o(period_match_irq_o)
);
